/* File: fifo_defines.vh */
// Constants for the bus-matching FIFO with retransmit
`ifndef FIFO_DEFINES_VH
`define FIFO_DEFINES_VH

`define FIFO_DEPTH          512
`define FIFO_ADDR_BITS      9
`define ALMOST_EMPTY_OFFSET 7
`define RT_SETUP_EDGES      2'h2
`define DATA_RESET          18'h00000

`define PIN_COUNT           30
`define PIN_WCLK            0
`define PIN_RCLK            1
`define PIN_WEN             2
`define PIN_REN             3
`define PIN_MRS             4
`define PIN_PRS             5
`define PIN_RT              6
`define PIN_ENDIAN          7
`define PIN_IN_NARROW       8
`define PIN_OUT_NARROW      9
`define PIN_FALL_THROUGH_MODE            10
`define PIN_RT_LATENCY      11
`define PIN_DATA_LSB        12
`define PIN_DATA_MSB        29

`endif

/* File: pin_sync.v */
// Two-stage pin synchroniser with rising edge detect
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out,
    output wire [WIDTH-1:0] rise_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second; edges come from stage two on
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
            prev_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_out = sync_reg;
    assign rise_out  = sync_reg & ~prev_reg;

endmodule // pin_sync

/* File: fifo_bus_matching.v */
// Bus-matching FIFO core: byte banks, flags, fall-through and retransmit
//
// The placing of the registers and strobed register access are this design's own decisions.
`include "fifo_defines.vh"

module fifo_bus_matching #(
    parameter DEPTH     = `FIFO_DEPTH,
    parameter AW        = `FIFO_ADDR_BITS,
    parameter AE_OFFSET = `ALMOST_EMPTY_OFFSET
) (
    input  wire        REF_CLK,
    input  wire        RST_B,
    input  wire        WRITE_CLOCK,
    input  wire        READ_CLOCK,
    input  wire        WRITE_EN_N,
    input  wire        READ_EN_N,
    input  wire [17:0] WRITE_DATA_IN,
    input  wire        MASTER_RESET_N,
    input  wire        PARTIAL_RESET_N,
    input  wire        RETRANSMIT_REQUEST,
    input  wire        ENDIAN_SELECT,
    input  wire        INPUT_WIDTH_SELECT,
    input  wire        OUTPUT_WIDTH_SELECT,
    input  wire        FALL_THROUGH_MODE,
    input  wire        RETRANSMIT_LATENCY_SELECT,
    output reg  [17:0] READ_DATA_OUT,
    output reg         FULL_FLAG_N,
    output reg         EMPTY_FLAG_N,
    output reg         ALMOST_EMPTY_FLAG_N
);

    localparam PW = AW + 2;
    localparam [PW-1:0] CAP     = 2 * DEPTH;
    localparam [PW-1:0] AE_TRIG = AE_OFFSET;
    localparam [PW-1:0] ONE     = 1;
    localparam [PW-1:0] TWO     = 2;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [`PIN_COUNT-1:0] pin_vec;
    wire [`PIN_COUNT-1:0] pin_lvl;
    wire [`PIN_COUNT-1:0] pin_rise;

    assign pin_vec = {WRITE_DATA_IN, RETRANSMIT_LATENCY_SELECT,
                      FALL_THROUGH_MODE, OUTPUT_WIDTH_SELECT,
                      INPUT_WIDTH_SELECT, ENDIAN_SELECT,
                      RETRANSMIT_REQUEST, PARTIAL_RESET_N,
                      MASTER_RESET_N, READ_EN_N, WRITE_EN_N,
                      READ_CLOCK, WRITE_CLOCK};

    pin_sync #(
        .WIDTH     (`PIN_COUNT)
    ) u_sync (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .pin_in    (pin_vec),
        .level_out (pin_lvl),
        .rise_out  (pin_rise)
    );

    wire        wclk_rise = pin_rise[`PIN_WCLK];
    wire        rclk_rise = pin_rise[`PIN_RCLK];
    wire        wen_n     = pin_lvl[`PIN_WEN];
    wire        ren_n     = pin_lvl[`PIN_REN];
    wire        mrs_n     = pin_lvl[`PIN_MRS];
    wire        prs_n     = pin_lvl[`PIN_PRS];
    wire        rt_req    = pin_lvl[`PIN_RT];
    wire [17:0] din       = pin_lvl[`PIN_DATA_MSB:`PIN_DATA_LSB];
    wire        running   = mrs_n & prs_n;

    ////////////////////////////////////////////////////////////////////////
    // Modes caught while master reset is held
    reg endian_reg;
    reg in_narrow_reg;
    reg out_narrow_reg;
    reg fall_through_mode_reg;
    reg rt_normal_reg;

    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            endian_reg     <= 1'b0;
            in_narrow_reg  <= 1'b0;
            out_narrow_reg <= 1'b0;
            fall_through_mode_reg       <= 1'b0;
            rt_normal_reg  <= 1'b0;
        end else if (!mrs_n) begin
            endian_reg     <= pin_lvl[`PIN_ENDIAN];
            in_narrow_reg  <= pin_lvl[`PIN_IN_NARROW];
            out_narrow_reg <= pin_lvl[`PIN_OUT_NARROW];
            fall_through_mode_reg       <= pin_lvl[`PIN_FALL_THROUGH_MODE];
            rt_normal_reg  <= pin_lvl[`PIN_RT_LATENCY];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers count 9-bit bytes; x18 words occupy one slot of each bank
    reg  [PW-1:0] wr_ptr_reg;
    reg  [PW-1:0] rd_ptr_reg;
    reg  [8:0]    bank0 [0:DEPTH-1];
    reg  [8:0]    bank1 [0:DEPTH-1];

    wire [PW-1:0] used     = wr_ptr_reg - rd_ptr_reg;
    wire [PW-1:0] wunit    = in_narrow_reg ? ONE : TWO;
    wire [PW-1:0] runit    = out_narrow_reg ? ONE : TWO;
    wire          full     = used > (CAP - wunit);
    wire          avail    = used >= runit;
    wire [PW-1:0] used_rd  = used - runit;
    wire          avail_rd = used_rd >= runit;

    wire          wr_go = wclk_rise & ~wen_n & running & ~full;

    wire [PW-1:0] used_wr = used + (wr_go ? wunit : {PW{1'b0}});
    wire          full_wr = used_wr > (CAP - wunit);

    ////////////////////////////////////////////////////////////////////////
    // Write steering
    wire [8:0]    d_hi   = din[17:9];
    wire [8:0]    d_lo   = din[8:0];
    wire          swap_w = out_narrow_reg & endian_reg;
    wire [AW-1:0] w_idx  = wr_ptr_reg[AW:1];

    always @(posedge REF_CLK) begin
        if (wr_go) begin
            if (in_narrow_reg) begin
                if (wr_ptr_reg[0])
                    bank1[w_idx] <= d_lo;
                else
                    bank0[w_idx] <= d_lo;
            end else begin
                bank0[w_idx] <= swap_w ? d_lo : d_hi;
                bank1[w_idx] <= swap_w ? d_hi : d_lo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read word fetch; zero-latency retransmit in fall-through mode fetches the first slot
    reg           rt_zero;
    wire [PW-1:0] fetch_ptr = rt_zero ? {PW{1'b0}} : rd_ptr_reg;
    wire [AW-1:0] r_idx     = fetch_ptr[AW:1];
    wire [8:0]    r_b0      = bank0[r_idx];
    wire [8:0]    r_b1      = bank1[r_idx];
    wire [8:0]    r_byte    = fetch_ptr[0] ? r_b1 : r_b0;
    reg  [17:0]   r_word;

    always @* begin
        if (out_narrow_reg)
            r_word = {9'h000, r_byte};
        else if (endian_reg)
            r_word = {r_b1, r_b0};
        else
            r_word = {r_b0, r_b1};
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side state
    reg [1:0] setup_cnt_reg;
    reg       out_valid_reg;
    reg       avail_seen_reg;

    wire rd_edge  = rclk_rise & running;
    wire words_ok = wr_ptr_reg >= runit;
    wire consume  = ~ren_n & out_valid_reg;
    wire ft_load  = (~out_valid_reg | consume) & avail_seen_reg & avail;
    wire [PW-1:0] ae_words = out_narrow_reg ? used : {1'b0, used[PW-1:1]};

    always @* begin
        rt_zero = rd_edge & rt_req & ~rt_normal_reg & fall_through_mode_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer, flag and output register update
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_ptr_reg          <= {PW{1'b0}};
            rd_ptr_reg          <= {PW{1'b0}};
            setup_cnt_reg       <= 2'h0;
            out_valid_reg       <= 1'b0;
            avail_seen_reg      <= 1'b0;
            READ_DATA_OUT       <= `DATA_RESET;
            FULL_FLAG_N         <= 1'b1;
            EMPTY_FLAG_N        <= 1'b0;
            ALMOST_EMPTY_FLAG_N <= 1'b0;
        end else if (!running) begin
            // Partial reset keeps modes and output data, master reloads modes from pins and clears data
            wr_ptr_reg          <= {PW{1'b0}};
            rd_ptr_reg          <= {PW{1'b0}};
            setup_cnt_reg       <= 2'h0;
            out_valid_reg       <= 1'b0;
            avail_seen_reg      <= 1'b0;
            if (!mrs_n) begin
                READ_DATA_OUT   <= `DATA_RESET;
                FULL_FLAG_N     <= ~pin_lvl[`PIN_FALL_THROUGH_MODE];
                EMPTY_FLAG_N    <= pin_lvl[`PIN_FALL_THROUGH_MODE];
            end else begin
                FULL_FLAG_N     <= ~fall_through_mode_reg;
                EMPTY_FLAG_N    <= fall_through_mode_reg;
            end
            ALMOST_EMPTY_FLAG_N <= 1'b0;
        end else begin
            if (wr_go)
                wr_ptr_reg <= wr_ptr_reg + wunit;
            // full sees read pointer as of this write edge
            if (wclk_rise)
                FULL_FLAG_N <= fall_through_mode_reg ? full_wr : ~full_wr;
            if (rd_edge) begin
                // almost-empty from count at read edge
                ALMOST_EMPTY_FLAG_N <= ae_words > AE_TRIG;
                if (rt_req) begin
                    // rewind to first word since reset
                    rd_ptr_reg     <= {PW{1'b0}};
                    avail_seen_reg <= 1'b0;
                    if (rt_normal_reg) begin
                        // setup hides data for a few edges
                        setup_cnt_reg <= `RT_SETUP_EDGES;
                        out_valid_reg <= 1'b0;
                        EMPTY_FLAG_N  <= fall_through_mode_reg;
                    end else if (fall_through_mode_reg) begin
                        if (words_ok) begin
                            READ_DATA_OUT <= r_word;
                            rd_ptr_reg    <= runit;
                            out_valid_reg <= 1'b1;
                            EMPTY_FLAG_N  <= 1'b0;
                        end else begin
                            out_valid_reg <= 1'b0;
                            EMPTY_FLAG_N  <= 1'b1;
                        end
                    end else begin
                        EMPTY_FLAG_N <= words_ok;
                    end
                end else if (setup_cnt_reg != 2'h0) begin
                    setup_cnt_reg <= setup_cnt_reg - 2'h1;
                    if (!fall_through_mode_reg)
                        EMPTY_FLAG_N <= (setup_cnt_reg == 2'h1) & avail;
                end else if (fall_through_mode_reg) begin
                    // availability must be seen one edge first
                    avail_seen_reg <= ft_load ? avail_rd : avail;
                    if (ft_load) begin
                        READ_DATA_OUT <= r_word;
                        rd_ptr_reg    <= rd_ptr_reg + runit;
                        out_valid_reg <= 1'b1;
                        EMPTY_FLAG_N  <= 1'b0;
                    end else if (consume) begin
                        // only a true read releases, data stays
                        out_valid_reg <= 1'b0;
                        EMPTY_FLAG_N  <= 1'b1;
                    end
                end else begin
                    // reads gated by the empty flag
                    if (!ren_n && EMPTY_FLAG_N) begin
                        READ_DATA_OUT <= r_word;
                        rd_ptr_reg    <= rd_ptr_reg + runit;
                        EMPTY_FLAG_N  <= avail_rd;
                    end else begin
                        // write seen on first read edge after it
                        EMPTY_FLAG_N <= avail;
                    end
                end
            end
        end
    end

endmodule // fifo_bus_matching

/* File: fifo_bus_matching_sva.sv */
// Pin-level checker for the bus-matching FIFO
module fifo_bus_matching_sva (
    input wire        REF_CLK,
    input wire        RST_B,
    input wire        WRITE_CLOCK,
    input wire        READ_CLOCK,
    input wire        WRITE_EN_N,
    input wire        READ_EN_N,
    input wire [17:0] WRITE_DATA_IN,
    input wire        MASTER_RESET_N,
    input wire        PARTIAL_RESET_N,
    input wire        RETRANSMIT_REQUEST,
    input wire        ENDIAN_SELECT,
    input wire        INPUT_WIDTH_SELECT,
    input wire        OUTPUT_WIDTH_SELECT,
    input wire        FALL_THROUGH_MODE,
    input wire        RETRANSMIT_LATENCY_SELECT,
    input wire [17:0] READ_DATA_OUT,
    input wire        FULL_FLAG_N,
    input wire        EMPTY_FLAG_N,
    input wire        ALMOST_EMPTY_FLAG_N
);
    logic [3:0] quiet_cnt, rd_age, wr_age;
    logic       rclk_d, wclk_d, ow_reg, fw_reg, ren_at, rt_at, quiet;
    // Pin resets act late, so hold checks off for eight cycles
    assign quiet = quiet_cnt == 4'h8;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            quiet_cnt <= 4'h0;
            rd_age <= 4'hf;
            wr_age <= 4'hf;
            rclk_d <= 1'b0;
            wclk_d <= 1'b0;
            ow_reg <= 1'b0;
            fw_reg <= 1'b0;
            ren_at <= 1'b1;
            rt_at <= 1'b0;
        end else begin
            rclk_d <= READ_CLOCK;
            wclk_d <= WRITE_CLOCK;
            if (!MASTER_RESET_N || !PARTIAL_RESET_N)
                quiet_cnt <= 4'h0;
            else if (!quiet)
                quiet_cnt <= quiet_cnt + 4'h1;
            if (!MASTER_RESET_N) begin
                ow_reg <= OUTPUT_WIDTH_SELECT;
                fw_reg <= FALL_THROUGH_MODE;
            end
            if (READ_CLOCK && !rclk_d) begin
                rd_age <= 4'h0;
                ren_at <= READ_EN_N;
                rt_at <= RETRANSMIT_REQUEST;
            end else if (rd_age != 4'hf)
                rd_age <= rd_age + 4'h1;
            if (WRITE_CLOCK && !wclk_d)
                wr_age <= 4'h0;
            else if (wr_age != 4'hf)
                wr_age <= wr_age + 4'h1;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    property p_narrow_out;
        quiet && ow_reg |-> READ_DATA_OUT[17:9] == 9'h0;
    endproperty
    a_narrow_out: assert property (p_narrow_out)
        else $error("upper output half driven in narrow mode");
    property p_data_at_read;
        quiet && $changed(READ_DATA_OUT) |-> rd_age inside {[1:6]};
    endproperty
    a_data_at_read: assert property (p_data_at_read)
        else $error("output data moved without a read edge");
    property p_empty_at_read;
        quiet && $changed(EMPTY_FLAG_N) |-> rd_age inside {[1:6]};
    endproperty
    a_empty_at_read: assert property (p_empty_at_read)
        else $error("empty flag moved without a read edge");
    property p_ae_at_read;
        quiet && $changed(ALMOST_EMPTY_FLAG_N) |-> rd_age inside {[1:6]};
    endproperty
    a_ae_at_read: assert property (p_ae_at_read)
        else $error("almost empty moved without a read edge");
    property p_full_at_edge;
        quiet && $changed(FULL_FLAG_N)
            |-> wr_age inside {[1:6]} || rd_age inside {[1:6]};
    endproperty
    a_full_at_edge: assert property (p_full_at_edge)
        else $error("full flag moved without a clock edge");
    property p_std_empty_hold;
        quiet && !fw_reg && !EMPTY_FLAG_N && $past(!EMPTY_FLAG_N)
            |-> $stable(READ_DATA_OUT);
    endproperty
    a_std_empty_hold: assert property (p_std_empty_hold)
        else $error("data changed while empty");
    property p_fall_through_mode_hold;
        quiet && fw_reg && EMPTY_FLAG_N |-> $stable(READ_DATA_OUT);
    endproperty
    a_fall_through_mode_hold: assert property (p_fall_through_mode_hold)
        else $error("data changed while output not ready");
    property p_ready_true_read;
        quiet && fw_reg && $rose(EMPTY_FLAG_N) |-> !ren_at || rt_at;
    endproperty
    a_ready_true_read: assert property (p_ready_true_read)
        else $error("output ready dropped without a true read");
endmodule // fifo_bus_matching_sva
bind fifo_bus_matching fifo_bus_matching_sva chk_u (
    .REF_CLK, .RST_B, .WRITE_CLOCK, .READ_CLOCK, .WRITE_EN_N, .READ_EN_N,
    .WRITE_DATA_IN, .MASTER_RESET_N, .PARTIAL_RESET_N, .RETRANSMIT_REQUEST,
    .ENDIAN_SELECT, .INPUT_WIDTH_SELECT, .OUTPUT_WIDTH_SELECT,
    .FALL_THROUGH_MODE, .RETRANSMIT_LATENCY_SELECT, .READ_DATA_OUT,
    .FULL_FLAG_N, .EMPTY_FLAG_N, .ALMOST_EMPTY_FLAG_N);

/* File: fifo_pin_agent.sv */
// Writer and reader pin model facing the FIFO
module fifo_pin_agent (
    input  wire         clk,
    output logic        wclk,
    output logic        rclk,
    output logic        wen_n,
    output logic        ren_n,
    output logic [17:0] wdata,
    output logic        rt_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {wclk, rclk, rt_req, wdata} = 21'h0;
        {wen_n, ren_n} = 2'h3;
    end
    task automatic xfer(input logic wr, en, rt, input logic [17:0] d);
        @(posedge clk);
        if (wr) {wen_n, wdata} <= {~en, d};
        else {ren_n, rt_req} <= {~en, rt};
        repeat (3) @(posedge clk);
        if (wr) wclk <= 1'b1;
        else rclk <= 1'b1;
        repeat (3) @(posedge clk);
        {wclk, rclk} <= 2'h0;
        repeat (3) @(posedge clk);
        // Released data bus shows inverted junk, not the last word
        {wen_n, ren_n, rt_req, wdata} <= {2'h3, 1'b0, ~d};
        @(negedge clk);
    endtask
endmodule // fifo_pin_agent

/* File: fifo_bus_matching_bench.sv */
// Self-checking bench for the bus-matching FIFO
`include "fifo_defines.vh"
module fifo_bus_matching_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, rst_b, mrs_n, be, iw, ow, fw, rm, have;
    logic        wclk, rclk, wen_n, ren_n, rt_req, full_n, empty_n, ae_n;
    logic [17:0] wdata, rdata, last;
    logic [31:0] seed;
    logic [8:0]  pend;
    logic [17:0] q[$], w[$];
    int          err_count, cmp_count, n;
    fifo_bus_matching #(.DEPTH(16), .AW(4), .AE_OFFSET(3)) dut_u (
        .REF_CLK(ref_clk), .RST_B(rst_b), .WRITE_CLOCK(wclk),
        .READ_CLOCK(rclk), .WRITE_EN_N(wen_n), .READ_EN_N(ren_n),
        .WRITE_DATA_IN(wdata), .MASTER_RESET_N(mrs_n),
        .PARTIAL_RESET_N(1'b1), .RETRANSMIT_REQUEST(rt_req),
        .ENDIAN_SELECT(be), .INPUT_WIDTH_SELECT(iw),
        .OUTPUT_WIDTH_SELECT(ow), .FALL_THROUGH_MODE(fw),
        .RETRANSMIT_LATENCY_SELECT(rm), .READ_DATA_OUT(rdata),
        .FULL_FLAG_N(full_n), .EMPTY_FLAG_N(empty_n),
        .ALMOST_EMPTY_FLAG_N(ae_n));
    fifo_pin_agent agent_u (.clk(ref_clk), .wclk(wclk), .rclk(rclk),
        .wen_n(wen_n), .ren_n(ren_n), .wdata(wdata), .rt_req(rt_req));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string nm, input logic [17:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic mreset(input logic [4:0] m);
        @(posedge ref_clk);
        {mrs_n, be, iw, ow, fw, rm} <= {1'b0, m};
        repeat (4) @(posedge ref_clk);
        mrs_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        q.delete();
        w.delete();
        have = 1'b0;
    endtask
    // Write one unit and queue what the reader must see
    task automatic put(input logic [17:0] d);
        agent_u.xfer(1'b1, 1'b1, 1'b0, d);
        w.push_back(d);
        if (!iw && !ow) q.push_back(be ? {d[8:0], d[17:9]} : d);
        else if (!iw) begin
            q.push_back({9'h0, be ? d[8:0] : d[17:9]});
            q.push_back({9'h0, be ? d[17:9] : d[8:0]});
        end else if (ow) q.push_back({9'h0, d[8:0]});
        else if (have) begin
            q.push_back(be ? {d[8:0], pend} : {pend, d[8:0]});
            have = 1'b0;
        end else {have, pend} = {1'b1, d[8:0]};
    endtask
    task automatic get(input string nm);
        agent_u.xfer(1'b0, 1'b1, 1'b0, 18'h0);
        chk(nm, q.pop_front(), rdata);
    endtask
    initial begin
        {rst_b, be, iw, ow, fw, rm, mrs_n} = 7'h3;
        {seed, err_count, cmp_count, have} = {32'd6335, 65'h0};
        repeat (5) @(posedge ref_clk);
        chk("reset", 18'h4, {rdata[14:0], full_n, empty_n, ae_n});
        rst_b <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            mreset({c[2:0], 2'h1});
            n = (c == 0) ? 16 : 4;
            for (int i = 0; i < n; i++) begin
                seed = xs(seed);
                put(seed[17:0]);
            end
            if (c == 0) chk("full", 18'h0, {17'h0, full_n});
            if (c == 0) agent_u.xfer(1'b1, 1'b1, 1'b0, 18'h15555);
            agent_u.xfer(1'b0, 1'b0, 1'b0, 18'h0);
            chk("empty after write", 18'h1, {17'h0, empty_n});
            if (c == 0) chk("almost empty", 18'h1, {17'h0, ae_n});
            while (q.size() > 0) get("data");
            last = rdata;
            chk("drained", 18'h0, {17'h0, empty_n});
            agent_u.xfer(1'b0, 1'b1, 1'b0, 18'h0);
            chk("blocked read", last, rdata);
            chk("almost empty low", 18'h0, {17'h0, ae_n});
        end
        mreset(5'h3);
        chk("fall_through_mode flags", 18'h1, {16'h0, full_n, empty_n});
        repeat (2) begin
            seed = xs(seed);
            put(seed[17:0]);
        end
        repeat (2) agent_u.xfer(1'b0, 1'b0, 1'b0, 18'h0);
        chk("ready", 18'h0, {17'h0, empty_n});
        chk("fall through", q.pop_front(), rdata);
        get("fall_through_mode next");
        agent_u.xfer(1'b0, 1'b1, 1'b0, 18'h0);
        chk("last held", w[1], rdata);
        chk("ready released", 18'h1, {17'h0, empty_n});
        for (int r = 0; r < 2; r++) begin
            // latency select held during master reset
            mreset({4'h0, r[0]});
            // three written, two read, then retransmit
            repeat (3) begin
                seed = xs(seed);
                put(seed[17:0]);
            end
            agent_u.xfer(1'b0, 1'b0, 1'b0, 18'h0);
            repeat (2) get("before rewind");
            agent_u.xfer(1'b0, 1'b0, 1'b1, 18'h0);
            for (n = 0; empty_n !== 1'b1 && n < 4; n++)
                agent_u.xfer(1'b0, 1'b0, 1'b0, 18'h0);
            chk("setup edges", r ? `RT_SETUP_EDGES : 18'h0, 18'(n));
            agent_u.xfer(1'b0, 1'b1, 1'b0, 18'h0);
            chk("rewind", w[0], rdata);
        end
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end
endmodule // fifo_bus_matching_bench
